// ### gsp_gci_port.sv
// Functional notes
// - Serial input carries 32 bits per 8 kHz frame, each bit two clocks.
// - Serial output pulls low only, 32 two-clock bits per 8 kHz frame.
// - Master mode: the port generates the 8 kHz frame sync itself.
// - Slave mode: three straps give binary channel number, top strap msb.
// - All eight slots need a bit clock of 4.096 MHz or faster.
// - Master mode: bit clock 1.536 MHz with rate strap high, else 512 kHz.
// - Master mode: shared strap pin outputs the B2 position sync.
// - Two local status inputs read back in bits 5 and 6.
// - Control output follows a latched bit until software rewrites it.
// - Mode strap low: clock and sync inputs; high: they are outputs.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module gsp_gci_port (
    input  wire logic        clock,               // system clock
    input  wire logic        rst_n,               // async reset
    input  wire logic [2:0]  avs_address,         // word address
    input  wire logic        avs_read,            // read request
    input  wire logic        avs_write,           // write request
    input  wire logic [31:0] avs_writedata,       // write data
    output logic      [31:0] avs_readdata,        // read data
    output logic             avs_waitrequest,     // stall
    input  wire logic        bitClkIn,            // partner bit clock
    output logic             bitClkOut,           // own bit clock
    output logic             bitClkOe,            // clock pin drive
    input  wire logic        primaryFrameSyncIn,  // partner sync
    output logic             primaryFrameSyncOut, // own sync
    output logic             primaryFrameSyncOe,  // sync pin drive
    input  wire logic        serialTxIn,          // data to line
    output logic             serialRxOut,         // open-drain level
    output logic             serialRxOe,          // pulls low
    input  wire logic        masterSlaveStrap,    // mode strap
    input  wire logic        slotMsbOrRateStrap,  // msb or rate
    input  wire logic        slotSelectMid,       // middle bit
    input  wire logic        slotLsbOrB2SyncIn,   // lsb strap
    output logic             slotLsbOrB2SyncOut,  // B2 sync
    output logic             slotLsbOrB2SyncOe,   // B2 pin drive
    input  wire logic        localStatusInOne,    // status in
    input  wire logic        localStatusInTwo,    // status in
    output logic             latchedControlOut    // latched bit
);

    // ---- system domain pin synchronisers ----

    logic [6:0] sysMeta_reg;
    logic [6:0] sysSync_reg;

    // two flops on every pin read by system logic
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sysMeta_reg <= '0;
            sysSync_reg <= '0;
        end else begin
            sysMeta_reg <= {masterSlaveStrap, slotMsbOrRateStrap, slotSelectMid,
                            slotLsbOrB2SyncIn, localStatusInTwo, localStatusInOne,
                            serialTxIn};
            sysSync_reg <= sysMeta_reg;
        end
    end

    // named views of the synchronised pins
    wire       masterSync = sysSync_reg[6];
    wire       rateSync   = sysSync_reg[5];
    wire [2:0] slotSys    = sysSync_reg[5:3];
    wire       es2Sync    = sysSync_reg[2];
    wire       es1Sync    = sysSync_reg[1];
    wire       txSync     = sysSync_reg[0];

    // ---- link domain reset and strap synchronisers ----

    logic [1:0] linkRst_reg;
    logic [3:0] linkMeta_reg;
    logic [3:0] linkSync_reg;

    // reset released on the link clock
    always_ff @(posedge bitClkIn or negedge rst_n) begin
        if (!rst_n) begin
            linkRst_reg <= 2'h0;
        end else begin
            linkRst_reg <= {linkRst_reg[0], 1'b1};
        end
    end

    wire linkRst_n = linkRst_reg[1];

    // straps seen by the link logic
    always_ff @(posedge bitClkIn or negedge linkRst_n) begin
        if (!linkRst_n) begin
            linkMeta_reg <= '0;
            linkSync_reg <= '0;
        end else begin
            linkMeta_reg <= {masterSlaveStrap, slotMsbOrRateStrap, slotSelectMid,
                             slotLsbOrB2SyncIn};
            linkSync_reg <= linkMeta_reg;
        end
    end

    wire [2:0] slotLink = linkSync_reg[2:0];

    // ---- register bus ----

    gsp_pkg::gsp_bus_state_t busState_reg;
    logic [31:0] outWord_reg;
    logic [31:0] inWord_reg;
    logic        lec_reg;
    logic        updToggle_reg;
    logic [7:0]  frameCnt_reg;

    // request decode
    wire busReq   = avs_read | avs_write;
    wire busIdle  = busState_reg == gsp_pkg::BUS_IDLE;
    wire busDone  = busState_reg == gsp_pkg::BUS_ACK;
    wire wrCommit = busDone & avs_write;
    wire selOut   = avs_address == gsp_pkg::REG_OUT_WORD;
    wire selIn    = avs_address == gsp_pkg::REG_IN_WORD;
    wire selRx    = avs_address == gsp_pkg::REG_RX_SPARE;
    wire selTx    = avs_address == gsp_pkg::REG_TX_SPARE;
    wire selSt    = avs_address == gsp_pkg::REG_STATUS;

    // read views, unused bits zero
    logic [31:0] rxSpareView;
    logic [31:0] txSpareView;
    logic [31:0] statusView;

    always_comb begin
        rxSpareView = '0;
        rxSpareView[gsp_pkg::ES1_BIT] = es1Sync;
        rxSpareView[gsp_pkg::ES2_BIT] = es2Sync;
        txSpareView = '0;
        txSpareView[gsp_pkg::LEC_BIT] = lec_reg;
        statusView = '0;
        statusView[gsp_pkg::ST_MODE_BIT] = masterSync;
        statusView[gsp_pkg::ST_SLOT_HI:gsp_pkg::ST_SLOT_LO] = slotSys;
        statusView[gsp_pkg::ST_CNT_HI:gsp_pkg::ST_CNT_LO] = frameCnt_reg;
    end

    // read selection, unmapped reads zero
    wire [31:0] rdMux = selOut ? outWord_reg :
                        selIn  ? inWord_reg  :
                        selRx  ? rxSpareView :
                        selTx  ? txSpareView :
                        selSt  ? statusView  : 32'h0000_0000;

    // one wait cycle on every access
    assign avs_waitrequest = busReq & busIdle;

    // bus sequencing and read capture
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busState_reg <= gsp_pkg::BUS_IDLE;
            avs_readdata <= '0;
        end else begin
            unique case (busState_reg)
                gsp_pkg::BUS_IDLE: begin
                    if (busReq) begin
                        busState_reg <= gsp_pkg::BUS_ACK;
                        avs_readdata <= rdMux;
                    end
                end
                gsp_pkg::BUS_ACK: begin
                    busState_reg <= gsp_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // software writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            outWord_reg   <= '0;
            updToggle_reg <= 1'b0;
            lec_reg       <= 1'b0;
        end else if (wrCommit) begin
            if (selOut) begin
                outWord_reg   <= avs_writedata;
                updToggle_reg <= ~updToggle_reg;
            end
            if (selTx) begin
                lec_reg <= avs_writedata[gsp_pkg::LEC_BIT];
            end
        end
    end

    assign latchedControlOut = lec_reg;

    // ---- master clock and frame generator ----

    logic [5:0] divCnt_reg;
    logic       bckOut_reg;
    logic [9:0] mCyc_reg;
    logic       fsOut_reg;
    logic       b2Out_reg;

    // rate and frame length from the rate strap
    wire [5:0] halfM1     = (rateSync ? gsp_pkg::HALF_FAST : gsp_pkg::HALF_SLOW) - 6'h01;
    wire [9:0] frameLen   = rateSync ? gsp_pkg::FRAME_FAST : gsp_pkg::FRAME_SLOW;
    wire       divEnd     = divCnt_reg == halfM1;
    wire       masterTick = masterSync & divEnd & ~bckOut_reg;
    wire [9:0] mCycNext   = (mCyc_reg >= frameLen - 10'h001) ? 10'h000 : mCyc_reg + 10'h001;
    wire       mFsNext    = masterTick ? (mCycNext == 10'h000) : fsOut_reg;

    // bit clock divider
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_reg <= '0;
            bckOut_reg <= 1'b0;
        end else if (!masterSync) begin
            divCnt_reg <= '0;
            bckOut_reg <= 1'b0;
        end else if (divEnd) begin
            divCnt_reg <= '0;
            bckOut_reg <= ~bckOut_reg;
        end else begin
            divCnt_reg <= divCnt_reg + 6'h01;
        end
    end

    // frame position and sync pulses
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mCyc_reg  <= '0;
            fsOut_reg <= 1'b0;
            b2Out_reg <= 1'b0;
        end else if (masterTick) begin
            mCyc_reg  <= mCycNext;
            fsOut_reg <= mCycNext == 10'h000;
            b2Out_reg <= mCycNext == gsp_pkg::B2_CYCLE;
        end
    end

    // ---- slot engines, one per mode ----

    gsp_pkg::gsp_engine_out_t mEng;
    gsp_pkg::gsp_engine_out_t sEng;
    logic [31:0] linkWord_reg;
    logic [2:0]  updSync_reg;

    // master: system clock, slot zero
    gsp_slot_engine u_master_engine (
        .clock     (clock),
        .rst_n     (rst_n),
        .tick      (masterTick),
        .frameSync (mFsNext),
        .serialIn  (txSync),
        .slotSel   (3'h0),
        .loadWord  (outWord_reg),
        .eng       (mEng)
    );

    // slave: partner clock, strapped slot
    gsp_slot_engine u_slave_engine (
        .clock     (bitClkIn),
        .rst_n     (linkRst_n),
        .tick      (1'b1),
        .frameSync (primaryFrameSyncIn),
        .serialIn  (serialTxIn),
        .slotSel   (slotLink),
        .loadWord  (linkWord_reg),
        .eng       (sEng)
    );

    // output word handed to the link on a toggle
    wire updEdge = updSync_reg[2] ^ updSync_reg[1];

    always_ff @(posedge bitClkIn or negedge linkRst_n) begin
        if (!linkRst_n) begin
            updSync_reg  <= '0;
            linkWord_reg <= '0;
        end else begin
            updSync_reg <= {updSync_reg[1:0], updToggle_reg};
            if (updEdge) begin
                linkWord_reg <= outWord_reg;
            end
        end
    end

    // captured word returns on a toggle
    logic [2:0]  capSync_reg;
    logic        mCapPrev_reg;

    wire sCapEdge = capSync_reg[2] ^ capSync_reg[1];
    wire mCapEdge = mEng.capToggle ^ mCapPrev_reg;
    wire capEvent = masterSync ? mCapEdge : sCapEdge;
    wire [31:0] capWord = masterSync ? mEng.capWord : sEng.capWord;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            capSync_reg  <= '0;
            mCapPrev_reg <= 1'b0;
            inWord_reg   <= '0;
            frameCnt_reg <= '0;
        end else begin
            capSync_reg  <= {capSync_reg[1:0], sEng.capToggle};
            mCapPrev_reg <= mEng.capToggle;
            if (capEvent) begin
                inWord_reg   <= capWord;
                frameCnt_reg <= frameCnt_reg + 8'h01;
            end
        end
    end

    // ---- pin drive ----

    assign bitClkOut           = bckOut_reg;
    assign bitClkOe            = masterSync;
    assign primaryFrameSyncOut = fsOut_reg;
    assign primaryFrameSyncOe  = masterSync;
    assign slotLsbOrB2SyncOut  = b2Out_reg;
    assign slotLsbOrB2SyncOe   = masterSync;
    assign serialRxOut         = 1'b0;
    assign serialRxOe          = masterSync ? mEng.driveLow : sEng.driveLow;

    // ---- checks ----

    property p_fs_start;
        @(posedge clock) disable iff (!rst_n) $rose(fsOut_reg) |-> mCyc_reg == 10'h000;
    endproperty
    a_fs_start: assert property (p_fs_start) else $error("frame sync off frame start");

    property p_rate;
        @(posedge clock) disable iff (!rst_n)
            (masterSync && $past(masterSync) && $changed(bckOut_reg)) |-> $past(divCnt_reg) == $past(halfM1);
    endproperty
    a_rate: assert property (p_rate) else $error("bit clock half period wrong");

    property p_b2;
        @(posedge clock) disable iff (!rst_n) $rose(b2Out_reg) |-> mCyc_reg == gsp_pkg::B2_CYCLE;
    endproperty
    a_b2: assert property (p_b2) else $error("B2 sync misplaced");

    property p_status;
        @(posedge clock) disable iff (!rst_n)
            (busIdle && avs_read && selRx) |=>
                avs_readdata[gsp_pkg::ES1_BIT] == $past(es1Sync) &&
                avs_readdata[gsp_pkg::ES2_BIT] == $past(es2Sync);
    endproperty
    a_status: assert property (p_status) else $error("status bits not read back");

    property p_lec_set;
        @(posedge clock) disable iff (!rst_n)
            (wrCommit && selTx) |=> latchedControlOut == $past(avs_writedata[gsp_pkg::LEC_BIT]);
    endproperty
    a_lec_set: assert property (p_lec_set) else $error("control output not updated");

    property p_lec_hold;
        @(posedge clock) disable iff (!rst_n) !(wrCommit && selTx) |=> $stable(latchedControlOut);
    endproperty
    a_lec_hold: assert property (p_lec_hold) else $error("control output moved");

    property p_slave_pins;
        @(posedge clock) disable iff (!rst_n)
            !masterSync |-> !bitClkOe && !primaryFrameSyncOe && !slotLsbOrB2SyncOe;
    endproperty
    a_slave_pins: assert property (p_slave_pins) else $error("slave drives clock or sync");

    property p_slot_status;
        @(posedge clock) disable iff (!rst_n)
            (busIdle && avs_read && selSt) |=>
                avs_readdata[gsp_pkg::ST_SLOT_HI:gsp_pkg::ST_SLOT_LO] == $past(slotSys);
    endproperty
    a_slot_status: assert property (p_slot_status) else $error("slot straps misread");

endmodule

// ### gsp_pkg.sv
package gsp_pkg;

    // system clock and link rates
    localparam int CLK_HZ      = 50_000_000;
    localparam int FAST_BCK_HZ = 1_536_000;
    localparam int SLOW_BCK_HZ = 512_000;
    localparam int FRAME_HZ    = 8_000;

    // divider half periods, rounded down
    localparam logic [5:0] HALF_FAST = 6'(CLK_HZ / (2 * FAST_BCK_HZ));
    localparam logic [5:0] HALF_SLOW = 6'(CLK_HZ / (2 * SLOW_BCK_HZ));

    // bit-clock cycles per frame in master mode
    localparam logic [9:0] FRAME_FAST = 10'(FAST_BCK_HZ / FRAME_HZ);
    localparam logic [9:0] FRAME_SLOW = 10'(SLOW_BCK_HZ / FRAME_HZ);

    // slot geometry
    localparam int         SLOT_BITS   = 32;
    localparam int         BIT_CYCLES  = 2;
    localparam logic [9:0] SLOT_CYCLES = 10'(SLOT_BITS * BIT_CYCLES);
    localparam logic [9:0] CYC_MAX     = 10'h3ff;
    localparam logic [9:0] B2_CYCLE    = 10'(8 * BIT_CYCLES);
    localparam logic [4:0] LAST_BIT    = 5'(SLOT_BITS - 1);
    localparam int         REL_PHASE   = 0;
    localparam int         REL_BIT_LO  = 1;
    localparam int         REL_BIT_HI  = 5;

    // register word indices
    localparam logic [2:0] REG_OUT_WORD = 3'h0;
    localparam logic [2:0] REG_IN_WORD  = 3'h1;
    localparam logic [2:0] REG_RX_SPARE = 3'h2;
    localparam logic [2:0] REG_TX_SPARE = 3'h3;
    localparam logic [2:0] REG_STATUS   = 3'h4;

    // field positions
    localparam int ES1_BIT     = 5;
    localparam int ES2_BIT     = 6;
    localparam int LEC_BIT     = 0;
    localparam int ST_MODE_BIT = 0;
    localparam int ST_SLOT_LO  = 1;
    localparam int ST_SLOT_HI  = 3;
    localparam int ST_CNT_LO   = 8;
    localparam int ST_CNT_HI   = 15;

    typedef enum {BUS_IDLE, BUS_ACK} gsp_bus_state_t;

    typedef struct packed {
        logic        driveLow;
        logic        capToggle;
        logic [31:0] capWord;
    } gsp_engine_out_t;

endpackage

// ### gsp_slot_engine.sv
`timescale 1ns/10ps
module gsp_slot_engine (
    input  wire logic        clock,     // domain clock
    input  wire logic        rst_n,     // domain reset
    input  wire logic        tick,      // a bit-clock period ends
    input  wire logic        frameSync, // frame sync level
    input  wire logic        serialIn,  // data toward the line
    input  wire logic [2:0]  slotSel,   // channel slot number
    input  wire logic [31:0] loadWord,  // word to send out
    output gsp_pkg::gsp_engine_out_t eng // drive, capture
);
    logic        fsPrev_reg;
    logic [9:0]  cyc_reg;
    logic [2:0]  slot_reg;
    logic [31:0] snap_reg;
    logic [30:0] shift_reg;
    logic        drive_reg;
    logic        capToggle_reg;
    logic [31:0] capWord_reg;

    // slot position and bit index decode; slot number held per frame so a moving strap cannot cut a slot
    wire        fsRise     = frameSync & ~fsPrev_reg;
    wire [2:0]  slotNext   = fsRise ? slotSel : slot_reg;
    wire [9:0]  slotStart  = 10'(slot_reg) * gsp_pkg::SLOT_CYCLES;
    wire [9:0]  startNext  = 10'(slotNext) * gsp_pkg::SLOT_CYCLES;
    wire [9:0]  rel        = cyc_reg - slotStart;
    wire        inSlot     = (cyc_reg >= slotStart) && (rel < gsp_pkg::SLOT_CYCLES);
    wire [9:0]  cycNext    = fsRise ? 10'h000 :
                             (cyc_reg == gsp_pkg::CYC_MAX) ? cyc_reg : cyc_reg + 10'h001;
    wire [9:0]  relNext    = cycNext - startNext;
    wire        inSlotNext = (cycNext >= startNext) && (relNext < gsp_pkg::SLOT_CYCLES);
    wire [31:0] wordNext   = fsRise ? loadWord : snap_reg;
    wire [4:0]  bitNext    = relNext[gsp_pkg::REL_BIT_HI:gsp_pkg::REL_BIT_LO];
    wire        outBit     = wordNext[gsp_pkg::LAST_BIT - bitNext];          // msb first
    wire        sampleNow  = inSlot && rel[gsp_pkg::REL_PHASE];
    wire        lastBit    = sampleNow &&
                             (rel[gsp_pkg::REL_BIT_HI:gsp_pkg::REL_BIT_LO] == gsp_pkg::LAST_BIT);

    // frame position and data register, advanced once per bit-clock period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fsPrev_reg    <= 1'b0;
            cyc_reg       <= gsp_pkg::CYC_MAX;
            slot_reg      <= '0;
            snap_reg      <= '0;
            shift_reg     <= '0;
            drive_reg     <= 1'b0;
            capToggle_reg <= 1'b0;
            capWord_reg   <= '0;
        end else if (tick) begin
            fsPrev_reg <= frameSync;
            cyc_reg    <= cycNext;
            slot_reg   <= slotNext;
            snap_reg   <= wordNext;
            drive_reg  <= inSlotNext & ~outBit;
            if (sampleNow) begin
                shift_reg <= {shift_reg[29:0], serialIn};
            end
            if (lastBit) begin
                capWord_reg   <= {shift_reg, serialIn};
                capToggle_reg <= ~capToggle_reg;
            end
        end
    end

    assign eng = '{driveLow: drive_reg, capToggle: capToggle_reg, capWord: capWord_reg};

    property p_release_outside;
        @(posedge clock) disable iff (!rst_n) drive_reg |-> inSlot;
    endproperty
    a_release_outside: assert property (p_release_outside) else $error("output pulled outside slot");

    property p_slot_offset;
        @(posedge clock) disable iff (!rst_n) (inSlot && !$past(inSlot)) |-> cyc_reg == slotStart;
    endproperty
    a_slot_offset: assert property (p_slot_offset) else $error("slot began at wrong cycle");

    property p_capture_last;
        @(posedge clock) disable iff (!rst_n)
            $changed(capToggle_reg) |-> $past(cyc_reg) == $past(slotStart) + gsp_pkg::SLOT_CYCLES - 10'h001;
    endproperty
    a_capture_last: assert property (p_capture_last) else $error("word captured off last bit");

    property p_hold_bit;
        @(posedge clock) disable iff (!rst_n)
            (tick && inSlot && inSlotNext && !rel[gsp_pkg::REL_PHASE]) |=> $stable(drive_reg);
    endproperty
    a_hold_bit: assert property (p_hold_bit) else $error("bit not held two cycles");

endmodule

// ### gsp_gci_partner.sv
`timescale 1ns/10ps
module gsp_gci_partner #(parameter int FRAME = 520) (
    input  wire logic        bitClk,    // link clock
    input  wire logic        rst_n,     // reset
    input  wire logic [2:0]  slot,      // channel slot
    input  wire logic [31:0] txWord,    // word sent to the port
    output logic             frameSync, // frame sync
    output logic             serialTx,  // data to the port
    input  wire logic        rxWire,    // open-drain wire level
    output logic             inSlot,    // slot window
    output logic [31:0]      rxWord,    // last word taken
    output logic             rxDone     // toggles per word
);
    int          cnt, nxt, rel, cur;
    logic [31:0] sh;
    // frame position, relative to the slot start
    assign nxt = (cnt + 1 == FRAME) ? 0 : cnt + 1;
    assign rel = nxt - 1 - 64 * int'(slot);
    assign cur = cnt - 1 - 64 * int'(slot);
    assign inSlot = cur >= 0 && cur < 64;
    // sync and data change after the rising edge; idle data toggles
    always @(posedge bitClk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            frameSync <= 0;
            serialTx <= 0;
        end else begin
            cnt <= nxt;
            frameSync <= nxt == 0;
            if (rel >= 0 && rel < 64) begin
                if (rel % 2 == 0) serialTx <= txWord[31 - rel / 2];
            end else serialTx <= ~serialTx;
        end
    end
    // sample the wire in the second cycle of each bit
    always @(negedge bitClk or negedge rst_n) begin
        if (!rst_n) begin
            sh <= 0;
            rxWord <= 0;
            rxDone <= 0;
        end else if (inSlot && cur % 2 == 1) begin
            sh <= {sh[30:0], rxWire};
            if (cur == 63) rxWord <= {sh[30:0], rxWire};
            if (cur == 63) rxDone <= ~rxDone;
        end
    end
endmodule

// ### tb_gsp_gci_port.sv
`timescale 1ns/10ps
module tb_gsp_gci_port;
    logic clock, rst_n, lclk, avs_read, avs_write, masterSlaveStrap, slotMsbOrRateStrap, slotSelectMid;
    logic localStatusInOne, localStatusInTwo, lsb, chkOd, pFs, serialTxIn, inSlot, rxDone, avs_waitrequest;
    logic bitClkOut, bitClkOe, primaryFrameSyncOut, primaryFrameSyncOe, serialRxOut, serialRxOe;
    logic slotLsbOrB2SyncOut, slotLsbOrB2SyncOe, latchedControlOut;
    logic [2:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, txWord, rxWord, seed, w, rq[$], sq[$];
    int error_cnt = 0, checks = 0, cyc = 0, n, h;
    // pin resolution: the port wins where it drives
    wire bitClkIn = bitClkOe ? bitClkOut : lclk;
    wire primaryFrameSyncIn = primaryFrameSyncOe ? primaryFrameSyncOut : pFs;
    wire slotLsbOrB2SyncIn = slotLsbOrB2SyncOe ? slotLsbOrB2SyncOut : lsb;
    wire rxWire = serialRxOe ? 1'b0 : 1'b1;
    wire [2:0] slot = {slotMsbOrRateStrap, slotSelectMid, lsb};
    gsp_gci_port gsp_gci_port_inst (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .bitClkIn, .bitClkOut, .bitClkOe, .primaryFrameSyncIn,
        .primaryFrameSyncOut, .primaryFrameSyncOe, .serialTxIn, .serialRxOut, .serialRxOe, .masterSlaveStrap,
        .slotMsbOrRateStrap, .slotSelectMid, .slotLsbOrB2SyncIn, .slotLsbOrB2SyncOut, .slotLsbOrB2SyncOe,
        .localStatusInOne, .localStatusInTwo, .latchedControlOut);
    gsp_gci_partner gsp_gci_partner_inst (.bitClk(bitClkIn), .rst_n, .slot, .txWord, .frameSync(pFs),
        .serialTx(serialTxIn), .rxWire, .inSlot, .rxWord, .rxDone);
    // clocks
    initial begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    initial begin
        lclk = 0;
        #7;
        forever #15 lclk = ~lclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(0, a, 0);
    endtask
    // cycles from the call up to the next rising edge of a port output
    task automatic rise(input int s, output int m);
        logic p, c;
        m = 0;
        c = 1;
        p = 1;
        while (!(c && !p) && m < 20000) begin
            @(posedge clock);
            p = c;
            c = s == 0 ? bitClkOut : s == 1 ? primaryFrameSyncOut : slotLsbOrB2SyncOut;
            m++;
        end
    endtask
    // result watchers
    always @(posedge clock) if (avs_read && avs_waitrequest === 1'b0 && rq.size() > 0) chk(avs_readdata, rq.pop_front());
    always @(rxDone) if (sq.size() > 0) chk(rxWord, sq.pop_front());
    always @(negedge bitClkIn) if (chkOd && !inSlot) chk({31'h0, serialRxOe}, 32'h0);
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        seed = 32'h0000_b665;
        {avs_read, avs_write, avs_address, avs_writedata} = 0;
        {rst_n, masterSlaveStrap, slotMsbOrRateStrap, slotSelectMid, lsb, chkOd} = 0;
        {localStatusInOne, localStatusInTwo} = 0;
        txWord = xs();
        repeat (12) @(posedge clock);
        rst_n <= 1;
        repeat (4) @(posedge clock);
        chk(32'({bitClkOe, primaryFrameSyncOe, slotLsbOrB2SyncOe, latchedControlOut, serialRxOut}), 32'h0);
        $display("reset test done");
        for (int i = 0; i < 2; i++) begin
            chkOd <= 0;
            {slotMsbOrRateStrap, slotSelectMid, lsb} <= i ? 3'h7 : 3'(xs());
            txWord <= xs();
            w = xs();
            bus(1, 3'h0, w);
            repeat (3) @(rxDone);
            chkOd <= 1;
            sq.push_back(w);
            @(rxDone);
            repeat (10) @(posedge clock);
            rd(3'h1, txWord);
        end
        bus(1, 3'h1, ~txWord);
        rd(3'h1, txWord);
        bus(1, 3'h5, xs());
        rd(3'h5, 32'h0);
        bus(0, 3'h4, 32'h0);
        chk(avs_readdata & 32'h0000_000f, 32'h0000_000e);
        $display("slave slot test done");
        for (int i = 0; i < 4; i++) begin
            {localStatusInTwo, localStatusInOne} <= 2'(i);
            repeat (4) @(posedge clock);
            rd(3'h2, 32'(i) << 5);
        end
        $display("status test done");
        for (int i = 0; i < 3; i++) begin
            w = xs();
            w[0] = i[0];
            bus(1, 3'h3, w);
            bus(1, 3'h0, ~w);
            chk(32'(latchedControlOut), 32'(w[0]));
        end
        $display("control test done");
        chkOd <= 0;
        masterSlaveStrap <= 1;
        for (int i = 0; i < 2; i++) begin
            slotMsbOrRateStrap <= !i;
            h = i ? 48 : 16;
            repeat (20) @(posedge clock);
            chk(32'({bitClkOe, primaryFrameSyncOe, slotLsbOrB2SyncOe}), 32'h7);
            rise(0, n);
            rise(0, n);
            chk(32'(n), 32'(2 * h));
            rise(1, n);
            rise(1, n);
            chk(32'(n), 32'h1800);
            rise(2, n);
            chk(32'(n), 32'(32 * h));
        end
        bus(0, 3'h4, 32'h0);
        chk(avs_readdata & 32'h0000_0001, 32'h0000_0001);
        $display("master test done");
        stop_test();
    end
endmodule
